// ### dgpio_pkg.sv
package dgpio_pkg;

    // --------------------------------------------------------------
    // register byte addresses
    // --------------------------------------------------------------
    localparam logic [5:0] DGPIO_PH_VAL_OFF = 6'h00;
    localparam logic [5:0] DGPIO_PH_LAT_OFF = 6'h04;
    localparam logic [5:0] DGPIO_PH_DIR_OFF = 6'h08;
    localparam logic [5:0] DGPIO_SEG_HI_OFF = 6'h0c;
    localparam logic [5:0] DGPIO_PJ_VAL_OFF = 6'h10;
    localparam logic [5:0] DGPIO_PJ_LAT_OFF = 6'h14;
    localparam logic [5:0] DGPIO_PJ_DIR_OFF = 6'h18;
    localparam logic [5:0] DGPIO_SEG_MD_OFF = 6'h1c;
    localparam logic [5:0] DGPIO_PG_VAL_OFF = 6'h20;

    // --------------------------------------------------------------
    // field positions and reset values
    // --------------------------------------------------------------
    localparam int DGPIO_PULLUP_BIT = 5;
    localparam logic [7:0] DGPIO_DIR_RST = 8'hff;
    localparam logic [7:0] DGPIO_LAT_RST = 8'h00;
    localparam logic [7:0] DGPIO_SEG_RST = 8'h00;
    localparam logic DGPIO_PULLUP_RST = 1'b0;
    localparam logic [7:0] DGPIO_SEG_MD_MASK = 8'hfe;
    localparam logic [1:0] DGPIO_RESP_OKAY = 2'b00;
    localparam logic [1:0] DGPIO_RESP_SLVERR = 2'b10;

    // pin drive bundle of one 8-bit port
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } dgpio_drive_t;

endpackage : dgpio_pkg

// ### dgpio_port.sv
`timescale 1ns/10ps

module dgpio_port #(
    parameter int PORT_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [5:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [5:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] ph_in,
    output dgpio_pkg::dgpio_drive_t ph_drv,
    input wire logic [7:0] pj_in,
    output dgpio_pkg::dgpio_drive_t pj_drv,
    output logic [7:0] pj_pullup_en,
    input wire logic [7:0] seg_wave_high,
    input wire logic [7:0] seg_wave_middle
);
    import dgpio_pkg::*;

    // ----------------------------------------------------------------
    // elaboration check
    // ----------------------------------------------------------------
    if (PORT_W != 8)
    begin : g_bad_width
        $error("dgpio_port supports only 8-bit ports");
    end

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    // segment 40+k vector into port h pin order
    function automatic logic [7:0] map_high(input logic [7:0] v);
        map_high = {v[3], v[2], v[1], v[0], v[4], v[5], v[6], v[7]};
    endfunction : map_high

    // segment 32+k vector into port j pin order, pin 0 has none
    function automatic logic [7:0] map_middle(input logic [7:0] v);
        map_middle = {v[4], v[5], v[6], v[7], v[3], v[2], v[1], 1'b0};
    endfunction : map_middle

    // pin mux: segment over port, direction 0 drives latch
    function automatic dgpio_drive_t pin_mux(input logic [7:0] lat,
        input logic [7:0] dir, input logic [7:0] sen,
        input logic [7:0] swv);
        dgpio_drive_t r;
        r.out = (sen & swv) | (~sen & lat);
        r.oe = sen | ~dir;
        return r;
    endfunction : pin_mux

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0] ph_lat_q, ph_dir_q, seg_hi_q;
    logic [7:0] pj_lat_q, pj_dir_q, seg_md_q;
    logic pullup_ctl_q;
    logic [7:0] ph_s1_q, ph_s2_q, pj_s1_q, pj_s2_q;
    logic [7:0] seh_pin, sem_pin;
    dgpio_drive_t ph_drv_d, pj_drv_d;
    logic [7:0] pj_pull_d;
    logic aw_held_q, w_held_q;
    logic [5:0] aw_addr_q;
    logic [7:0] w_data_q;
    logic w_lane0_q;
    logic do_write, wr_hit;
    logic [31:0] rd_data_d;
    logic rd_hit;

    // ----------------------------------------------------------------
    // pin input synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ph_s1_q <= 8'h00;
            ph_s2_q <= 8'h00;
            pj_s1_q <= 8'h00;
            pj_s2_q <= 8'h00;
        end
        else if (ce)
        begin
            ph_s1_q <= ph_in;
            ph_s2_q <= ph_s1_q;
            pj_s1_q <= pj_in;
            pj_s2_q <= pj_s1_q;
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite write path
    // ----------------------------------------------------------------
    // readies low while frozen, so no handshake is lost
    assign s_axi_awready = ce && !aw_held_q && !s_axi_bvalid;
    assign s_axi_wready = ce && !w_held_q && !s_axi_bvalid;
    assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;

    // address and data may arrive in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            aw_addr_q <= 6'h00;
            w_data_q <= 8'h00;
            w_lane0_q <= 1'b0;
        end
        else if (ce)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            else if (do_write)
            begin
                aw_held_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata[7:0];
                w_lane0_q <= s_axi_wstrb[0];
            end
            else if (do_write)
            begin
                w_held_q <= 1'b0;
            end
        end
    end

    // decode of the held write address
    always_comb
    begin
        unique case (aw_addr_q)
            DGPIO_PH_VAL_OFF, DGPIO_PH_LAT_OFF, DGPIO_PH_DIR_OFF,
            DGPIO_SEG_HI_OFF, DGPIO_PJ_VAL_OFF, DGPIO_PJ_LAT_OFF,
            DGPIO_PJ_DIR_OFF, DGPIO_SEG_MD_OFF,
            DGPIO_PG_VAL_OFF: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // write response one cycle after both halves are held
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= DGPIO_RESP_OKAY;
        end
        else if (ce)
        begin
            if (do_write)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? DGPIO_RESP_OKAY : DGPIO_RESP_SLVERR;
            end
            else if (s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    // port h, port j and pull-up control registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ph_lat_q <= DGPIO_LAT_RST;
            ph_dir_q <= DGPIO_DIR_RST;
            seg_hi_q <= DGPIO_SEG_RST;
            pj_lat_q <= DGPIO_LAT_RST;
            pj_dir_q <= DGPIO_DIR_RST;
            seg_md_q <= DGPIO_SEG_RST;
            pullup_ctl_q <= DGPIO_PULLUP_RST;
        end
        else if (ce && do_write && w_lane0_q)
        begin
            unique case (aw_addr_q)
                DGPIO_PH_VAL_OFF, DGPIO_PH_LAT_OFF: ph_lat_q <= w_data_q;
                DGPIO_PH_DIR_OFF: ph_dir_q <= w_data_q;
                DGPIO_SEG_HI_OFF: seg_hi_q <= w_data_q;
                DGPIO_PJ_VAL_OFF, DGPIO_PJ_LAT_OFF: pj_lat_q <= w_data_q;
                DGPIO_PJ_DIR_OFF: pj_dir_q <= w_data_q;
                DGPIO_SEG_MD_OFF:
                    seg_md_q <= w_data_q & DGPIO_SEG_MD_MASK;
                DGPIO_PG_VAL_OFF:
                    pullup_ctl_q <= w_data_q[DGPIO_PULLUP_BIT];
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite read path
    // ----------------------------------------------------------------
    assign s_axi_arready = ce && !s_axi_rvalid;

    always_comb
    begin
        rd_data_d = 32'h0000_0000;
        rd_hit = 1'b1;
        unique case (s_axi_araddr)
            DGPIO_PH_VAL_OFF: rd_data_d[7:0] = ph_s2_q;
            DGPIO_PH_LAT_OFF: rd_data_d[7:0] = ph_lat_q;
            DGPIO_PH_DIR_OFF: rd_data_d[7:0] = ph_dir_q;
            DGPIO_SEG_HI_OFF: rd_data_d[7:0] = seg_hi_q;
            DGPIO_PJ_VAL_OFF: rd_data_d[7:0] = pj_s2_q;
            DGPIO_PJ_LAT_OFF: rd_data_d[7:0] = pj_lat_q;
            DGPIO_PJ_DIR_OFF: rd_data_d[7:0] = pj_dir_q;
            DGPIO_SEG_MD_OFF: rd_data_d[7:0] = seg_md_q;
            DGPIO_PG_VAL_OFF: rd_data_d[DGPIO_PULLUP_BIT] = pullup_ctl_q;
            default: rd_hit = 1'b0;
        endcase
    end

    // read data one cycle after the address is taken
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= DGPIO_RESP_OKAY;
        end
        else if (ce)
        begin
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_data_d;
                s_axi_rresp <= rd_hit ? DGPIO_RESP_OKAY : DGPIO_RESP_SLVERR;
            end
            else if (s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // pin muxing
    // ----------------------------------------------------------------
    // high and middle segment maps
    assign seh_pin = map_high(seg_hi_q);
    assign sem_pin = map_middle(seg_md_q);

    always_comb
    begin
        ph_drv_d = pin_mux(ph_lat_q, ph_dir_q, seh_pin,
            map_high(seg_wave_high));
        pj_drv_d = pin_mux(pj_lat_q, pj_dir_q, sem_pin,
            map_middle(seg_wave_middle));
        pj_pull_d = {8{pullup_ctl_q}} & ~pj_drv_d.oe;
    end

    // registered pin drivers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ph_drv <= '0;
            pj_drv <= '0;
            pj_pullup_en <= 8'h00;
        end
        else if (ce)
        begin
            ph_drv <= ph_drv_d;
            pj_drv <= pj_drv_d;
            pj_pullup_en <= pj_pull_d;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    AST_RESET_INPUTS: assert property (@(posedge aclk)
        !aresetn |=> pj_dir_q == 8'hff && pj_drv.oe == 8'h00)
        else $error("port j not input after reset");

    AST_RESET_PULLUP: assert property (@(posedge aclk)
        !aresetn |=> !pullup_ctl_q && pj_pullup_en == 8'h00)
        else $error("pull-ups on after reset");

    AST_SEGMENT_47_OUTPUT_PIN0: assert property (@(posedge aclk)
        disable iff (!aresetn)
        $past(ce) && $past(seg_hi_q[7]) |->
        ph_drv.oe[0] && ph_drv.out[0] == $past(seg_wave_high[7]))
        else $error("segment 47 not on port h pin 0");

    AST_SEG33_PIN1: assert property (@(posedge aclk)
        disable iff (!aresetn)
        $past(ce) && $past(seg_md_q[1]) |->
        pj_drv.oe[1] && pj_drv.out[1] == $past(seg_wave_middle[1]))
        else $error("segment 33 not on port j pin 1");

    AST_SEG_IGNORES_DIR: assert property (@(posedge aclk)
        disable iff (!aresetn)
        $past(ce) |-> (ph_drv.oe & $past(seh_pin)) == $past(seh_pin))
        else $error("segment pin not driven");

    AST_LATCH_DRIVE: assert property (@(posedge aclk)
        disable iff (!aresetn)
        $past(ce) |-> ((ph_drv.out ^ $past(ph_lat_q))
        & $past(~ph_dir_q & ~seh_pin)) == 8'h00)
        else $error("output pin not from latch");

    AST_INPUT_FLOATS: assert property (@(posedge aclk)
        disable iff (!aresetn)
        $past(ce) |-> (pj_drv.oe & $past(pj_dir_q & ~sem_pin)) == 8'h00)
        else $error("input pin driven");

    AST_PULLUP_GATE: assert property (@(posedge aclk)
        disable iff (!aresetn)
        $past(ce) |-> pj_pullup_en ==
        ({8{$past(pullup_ctl_q)}} & $past(pj_dir_q & ~sem_pin)))
        else $error("pull-up gating wrong");

    AST_VAL_WRITE_LATCH: assert property (@(posedge aclk)
        disable iff (!aresetn)
        ce && do_write && w_lane0_q && aw_addr_q == DGPIO_PJ_VAL_OFF
        |=> pj_lat_q == $past(w_data_q))
        else $error("pin value write missed latch");

    AST_BRESP_NEXT: assert property (@(posedge aclk)
        disable iff (!aresetn)
        ce && do_write |=> s_axi_bvalid)
        else $error("write response late");

    COV_SEG_H: cover property (@(posedge aclk) disable iff (!aresetn)
        ce && seg_hi_q != 8'h00 ##1 ph_drv.oe != 8'h00);
    COV_PULLUP: cover property (@(posedge aclk) disable iff (!aresetn)
        pj_pullup_en != 8'h00);
    COV_READ: cover property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && s_axi_rready);

endmodule : dgpio_port

// ### dgpio_pin_model.sv
`timescale 1ns/10ps

// ----------------------------------------
// pin model for one 8-bit port
// ----------------------------------------
module dgpio_pin_model
(
    input wire logic aclk,
    input wire dgpio_pkg::dgpio_drive_t drv,
    input wire logic [7:0] pull_en,
    input wire logic [7:0] ext_val,
    input wire logic [7:0] ext_en,
    output logic [7:0] pin
);
    import dgpio_pkg::*;
    logic [7:0] float_q = 8'h5a;

    // undriven lines wander every cycle
    always_ff @(posedge aclk)
    begin
        float_q <= ~float_q;
    end

    // resolve each line from its drivers
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (drv.oe[i])
                pin[i] = drv.out[i];
            else if (ext_en[i])
                pin[i] = ext_val[i];
            else if (pull_en[i])
                pin[i] = 1'b1;
            else
                pin[i] = float_q[i];
        end
    end
endmodule : dgpio_pin_model

// ### dgpio_port_tb_top.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_checks++; if ((e) !== (g)) begin fail_count++; $display("MISMATCH %s exp %h got %h", n, e, g); end end

module dgpio_port_tb_top;
    import dgpio_pkg::*;
    localparam logic [1:0] OK = DGPIO_RESP_OKAY;
    logic aclk = 0, aresetn = 0, ce = 1;
    logic [5:0] awaddr = 0, araddr = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [31:0] wdata = 0, rdata, rng = 32'h8e73;
    logic [3:0] wstrb = 4'hf;
    logic [1:0] bresp, rresp;
    logic [7:0] ph_in, pj_in, pj_pullup_en, swh = 0, swm = 0;
    logic [7:0] exh = 0, exj = 0, exj_en = 8'hff;
    logic [7:0] lh, dh, sh, lj, dj, sj;
    logic ctl;
    dgpio_drive_t ph_drv, pj_drv, eh, ej;
    int fail_count = 0, n_checks = 0;

    dgpio_port u_dgpio_port (.aclk(aclk), .aresetn(aresetn), .ce(ce),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .ph_in(ph_in), .ph_drv(ph_drv),
        .pj_in(pj_in), .pj_drv(pj_drv), .pj_pullup_en(pj_pullup_en),
        .seg_wave_high(swh), .seg_wave_middle(swm));
    dgpio_pin_model u_dgpio_pin_model_h (.aclk(aclk), .drv(ph_drv),
        .pull_en(8'h00), .ext_val(exh), .ext_en(8'hff), .pin(ph_in));
    dgpio_pin_model u_dgpio_pin_model_j (.aclk(aclk), .drv(pj_drv),
        .pull_en(pj_pullup_en), .ext_val(exj), .ext_en(exj_en), .pin(pj_in));

    // 50 MHz clock
    initial
    begin
        forever #10 aclk = ~aclk;
    end

    // xorshift source
    function logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : xs

    // expected pin drive of one port
    function automatic dgpio_drive_t xd(input logic [7:0] l, d, s, w,
                                        input bit j);
        dgpio_drive_t r;
        int k;
        logic e;
        for (int i = 0; i < 8; i++)
        begin
            k = j ? ((i < 4) ? i : 11 - i) : ((i < 4) ? 7 - i : i - 4);
            e = s[k] && !(j && i == 0);
            r.oe[i] = e | ~d[i];
            r.out[i] = e ? w[k] : l[i];
        end
        return r;
    endfunction : xd

    // ----------------------------------------
    // bus tasks
    // ----------------------------------------
    task automatic wr(input logic [5:0] a, input logic [7:0] d,
                      input logic [1:0] er);
        bit ad, wd;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        ad = 0;
        wd = 0;
        while (!(ad && wd))
        begin
            @(posedge aclk);
            if (!ad && awready)
            begin
                ad = 1;
                awvalid <= 1'b0;
            end
            if (!wd && wready)
            begin
                wd = 1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!bvalid);
        bready <= 1'b0;
        `CHK("bresp", er, bresp)
    endtask : wr

    task automatic rd(input logic [5:0] a, input logic [1:0] er,
                      input logic [7:0] ed, input logic [7:0] m);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rready <= 1'b0;
        `CHK("rresp", er, rresp)
        `CHK("rdata", {24'h0, ed & m}, rdata & {24'hffffff, m})
    endtask : rd

    // ----------------------------------------
    // checks of pins and registers
    // ----------------------------------------
    task automatic chk_all();
        logic [7:0] ph, pj, mj;
        eh = xd(lh, dh, sh, swh, 0);
        ej = xd(lj, dj, sj, swm, 1);
        repeat (4) @(posedge aclk);
        `CHK("ph_oe", eh.oe, ph_drv.oe)
        `CHK("ph_out", eh.out & eh.oe, ph_drv.out & ph_drv.oe)
        `CHK("pj_oe", ej.oe, pj_drv.oe)
        `CHK("pj_out", ej.out & ej.oe, pj_drv.out & pj_drv.oe)
        `CHK("pullup", ctl ? dj & ~ej.oe : 8'h00, pj_pullup_en)
        ph = (eh.oe & eh.out) | (~eh.oe & exh);
        pj = (ej.oe & ej.out) | (~ej.oe & ((exj_en & exj) | ~exj_en));
        mj = ej.oe | exj_en | (ctl ? dj : 8'h00);
        rd(DGPIO_PH_VAL_OFF, OK, ph, 8'hff);
        rd(DGPIO_PJ_VAL_OFF, OK, pj, mj);
        rd(DGPIO_PH_LAT_OFF, OK, lh, 8'hff);
        rd(DGPIO_PH_DIR_OFF, OK, dh, 8'hff);
        rd(DGPIO_SEG_HI_OFF, OK, sh, 8'hff);
        rd(DGPIO_PJ_LAT_OFF, OK, lj, 8'hff);
        rd(DGPIO_PJ_DIR_OFF, OK, dj, 8'hff);
        rd(DGPIO_SEG_MD_OFF, OK, sj & DGPIO_SEG_MD_MASK, 8'hff);
        rd(DGPIO_PG_VAL_OFF, OK, {2'b0, ctl, 5'b0}, 8'hff);
    endtask : chk_all

    task automatic do_reset();
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        {lh, dh, sh, lj, dj, sj, ctl} = {8'h00, 8'hff, 16'h0, 8'hff, 9'h0};
    endtask : do_reset

    task automatic cfg();
        logic [31:0] r;
        r = xs();
        wr(r[0] ? DGPIO_PH_VAL_OFF : DGPIO_PH_LAT_OFF, lh, OK);
        wr(r[1] ? DGPIO_PJ_VAL_OFF : DGPIO_PJ_LAT_OFF, lj, OK);
        wr(DGPIO_PH_DIR_OFF, dh, OK);
        wr(DGPIO_SEG_HI_OFF, sh, OK);
        wr(DGPIO_PJ_DIR_OFF, dj, OK);
        wr(DGPIO_SEG_MD_OFF, sj, OK);
        wr(DGPIO_PG_VAL_OFF, {r[15:14], ctl, r[12:8]}, OK);
        chk_all();
    endtask : cfg

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : close_out

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        logic [31:0] r;
        logic [7:0] ee;
        do_reset();
        chk_all();
        $display("test reset done");
        wr(6'h24, 8'hff, DGPIO_RESP_SLVERR);
        // lane 0 strobe off: answered, nothing stored
        wstrb <= 4'h0;
        wr(DGPIO_PH_LAT_OFF, 8'ha5, OK);
        wstrb <= 4'hf;
        rd(6'h3c, DGPIO_RESP_SLVERR, 8'h00, 8'hff);
        chk_all();
        $display("test unmapped done");
        for (int n = 0; n < 40; n++)
        begin
            r = xs();
            {lh, dh, sh, lj} = r;
            r = xs();
            {dj, sj} = r[15:0];
            exh <= r[23:16];
            exj <= r[31:24];
            r = xs();
            ctl = r[0];
            ee = r[15:8];
            swh <= r[23:16];
            swm <= r[31:24];
            // corners: all segments, all port j outputs, pull-ups seen
            if (n == 0)
                {sh, sj} = 16'hffff;
            if (n == 1)
                {dj, sj, ctl} = {16'h0, 1'b1};
            if (n == 2)
                {dj, sj, ctl, ee} = {8'hff, 8'h0, 1'b1, 8'h0};
            exj_en <= ee;
            cfg();
        end
        $display("test random done");
        // clock enable low: pins hold, segment waves ignored
        eh = xd(lh, dh, sh, swh, 0);
        ej = xd(lj, dj, sj, swm, 1);
        ce <= 1'b0;
        swh <= ~swh;
        swm <= ~swm;
        repeat (6) @(posedge aclk);
        `CHK("ce_ph", eh, ph_drv)
        `CHK("ce_pj", ej, pj_drv)
        ce <= 1'b1;
        chk_all();
        $display("test clock enable done");
        do_reset();
        chk_all();
        $display("test second reset done");
        close_out();
    end

    // hang guard
    initial
    begin
        repeat (30000) @(posedge aclk);
        fail_count++;
        close_out();
    end
endmodule : dgpio_port_tb_top
